/* nus_seq.sv */
// memory unlock and eeprom sequencer: control registers, key check,
// timed erase and program of the data eeprom
// assumes the core issues one register or table access per clock
//
// Contract
// - keys 55 then aa before go
// - control layout go arm abort timed opcode
// - address low and high, not reset
// - word and sixteen-word block operations
// - 4k words mapped from 7ff000
// - erase or program takes about 2 ms
// - core never stalled by eeprom operation
// - reads during operation are unspecified
// - go only set by software
// - arm cleared at power-up only; here master reset rstn clears it too
// - reset mid-operation sets abort, keeps address
// - completion clears go, sets done flag
// - clearing arm leaves running operation alone
// - go needs arm from earlier write
// - 4045 selects block erase
// - 4044 selects word erase
// - 4004 selects word program
// - 400a selects block program
// - flash operation stalls core, clears go
`timescale 1ns/10ps
module nus_seq #(
    parameter int OP_CYCLES = nus_pkg::NUS_OP_CYCLES
) (
    // clock and resets
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  por_n,
    // register port
    input  wire nus_pkg::nus_sfr_req_t sfr_req,
    output logic                [15:0] sfr_rdata,
    // table access port
    input  wire nus_pkg::nus_tbl_req_t tbl_req,
    output logic                [15:0] tbl_rdata,
    // status to the core
    output logic                       core_stall,
    output logic                       done_flag,
    input  wire logic                  done_flag_clr
);
    import nus_pkg::*;

    // =========================================================
    // registers and decode
    logic                   go_q, arm_q, abort_q, timed_q;
    logic [NUS_OP_W-1:0]    op_q;
    logic [15:0]            adr_lo_q;
    logic [7:0]             adr_hi_q;
    logic                   key1_q, key2_q;
    logic                   done_q;
    nus_state_t             state_q;
    logic [31:0]            cnt_q;
    logic [NUS_BLK_AW-1:0]  idx_q;
    logic [15:0]            latch_q [NUS_BLK_WORDS];
    logic                   wr_ctrl, wr_key, go_req, go_ok, finish;
    logic                   ee_hit, is_flash;
    logic [23:0]            adr_full;
    logic [NUS_EE_AW-1:0]   ee_word, mem_waddr, mem_raddr;
    logic                   mem_we;
    logic [15:0]            mem_wdata, mem_rdata;

    assign wr_ctrl  = sfr_req.wr && sfr_req.addr == NUS_ADDR_CTRL;
    assign wr_key   = sfr_req.wr && sfr_req.addr == NUS_ADDR_KEY;
    assign go_req   = wr_ctrl && sfr_req.wdata[NUS_BIT_GO] && !go_q;
    assign go_ok    = go_req && key2_q && arm_q;
    assign adr_full = {adr_hi_q, adr_lo_q};
    assign ee_hit   = adr_full >= NUS_EE_BASE;
    assign ee_word  = adr_full[NUS_EE_AW:1];
    assign is_flash = !ee_hit;
    assign finish   = state_q != NUS_IDLE && cnt_q == 32'(OP_CYCLES - 1);

    // =========================================================
    // unlock key tracker
    // any other register write breaks unlock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            key1_q <= 1'b0;
            key2_q <= 1'b0;
        end else if (sfr_req.wr) begin
            key1_q <= wr_key && sfr_req.wdata[7:0] == NUS_KEY_FIRST;
            key2_q <= wr_key && key1_q &&
                      sfr_req.wdata[7:0] == NUS_KEY_SECOND;
        end
    end

    // =========================================================
    // control register
    // layout and reset
    // arm only cleared by reset or software
    // arm writes do not touch running op
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arm_q   <= NUS_CTRL_RESET[NUS_BIT_ARM];
            timed_q <= NUS_CTRL_RESET[NUS_BIT_TIMED];
            op_q    <= NUS_CTRL_RESET[NUS_OP_W-1:0];
        end else if (wr_ctrl) begin
            arm_q   <= sfr_req.wdata[NUS_BIT_ARM];
            timed_q <= sfr_req.wdata[NUS_BIT_TIMED];
            op_q    <= sfr_req.wdata[NUS_OP_W-1:0];
        end
    end

    // go bit: set by software, cleared only by hardware
    // zero writes ignored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            go_q <= NUS_CTRL_RESET[NUS_BIT_GO];
        end else if (go_ok) begin
            go_q <= 1'b1;
        end else if (finish) begin
            go_q <= 1'b0;
        end
    end

    // =========================================================
    // running-op memory on the power-up reset only: master reset
    // clears go at once, so the abort set cannot look at go itself
    logic run_q;
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= rstn && go_q;
        end
    end

    // abort flag, survives master reset, cleared at power-up
    // interrupted op sets abort
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            abort_q <= NUS_CTRL_RESET[NUS_BIT_ABORT];
        end else if (!rstn && run_q) begin
            abort_q <= 1'b1;
        end else if (rstn && wr_ctrl) begin
            abort_q <= sfr_req.wdata[NUS_BIT_ABORT];
        end
    end

    // address registers: no reset, last table access or direct write
    // address kept across reset
    always_ff @(posedge clk) begin
        if (sfr_req.wr && sfr_req.addr == NUS_ADDR_ADR_LO) begin
            adr_lo_q <= sfr_req.wdata;
        end else if (tbl_req.wr || tbl_req.rd) begin
            adr_lo_q <= tbl_req.addr[15:0];
        end
        if (sfr_req.wr && sfr_req.addr == NUS_ADDR_ADR_HI) begin
            adr_hi_q <= sfr_req.wdata[7:0];
        end else if (tbl_req.wr || tbl_req.rd) begin
            adr_hi_q <= tbl_req.addr[23:16];
        end
    end

    // =========================================================
    // write latches filled by table writes
    // sixteen-word block latches
    always_ff @(posedge clk) begin
        if (tbl_req.wr) begin
            latch_q[tbl_req.addr[NUS_BLK_AW:1]] <= tbl_req.wdata;
        end
    end

    // =========================================================
    // sequencer
    // timed operation
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= NUS_IDLE;
            cnt_q   <= 32'h0000_0000;
            idx_q   <= '0;
        end else begin
            unique case (state_q)
                NUS_IDLE: begin
                    cnt_q <= 32'h0000_0000;
                    idx_q <= '0;
                    if (go_ok) begin
                        if (op_q == NUS_OP_BLK_ERASE ||
                            op_q == NUS_OP_WRD_ERASE) begin
                            state_q <= NUS_ERASE;
                        end else if (op_q == NUS_OP_WRD_PROG ||
                                     op_q == NUS_OP_BLK_PROG) begin
                            state_q <= NUS_PROG;
                        end else begin
                            state_q <= NUS_WAIT;
                        end
                    end
                end
                NUS_ERASE, NUS_PROG, NUS_WAIT: begin
                    if (idx_q != '1) begin
                        idx_q <= idx_q + 1'b1;
                    end
                    if (finish) begin
                        state_q <= NUS_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                default: state_q <= NUS_IDLE;
            endcase
        end
    end

    // array write: one word per cycle during the first block cycles of a block op, in the first cycle only for a word op
    logic blk_op, wr_phase;
    assign blk_op   = op_q == NUS_OP_BLK_ERASE || op_q == NUS_OP_BLK_PROG;
    assign wr_phase = ee_hit && (blk_op ? (cnt_q < NUS_BLK_WORDS)
                                        : (cnt_q == 32'h0000_0000));
    assign mem_we   = (state_q == NUS_ERASE || state_q == NUS_PROG)
                      && wr_phase;
    assign mem_waddr = blk_op ? {ee_word[NUS_EE_AW-1:NUS_BLK_AW], idx_q}
                              : ee_word;
    assign mem_wdata = state_q == NUS_ERASE ? NUS_ERASED
                     : latch_q[blk_op ? idx_q : ee_word[NUS_BLK_AW-1:0]];
    assign mem_raddr = tbl_req.addr[NUS_EE_AW:1];

    nus_mem #(
        .AW(NUS_EE_AW),
        .DW(16)
    ) u_mem (
        .clk  (clk),
        .we   (mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );
    assign tbl_rdata = mem_rdata;

    // =========================================================
    // done flag, set wins over clear
    // done flag sticky
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (done_flag_clr) begin
            done_q <= 1'b0;
        end
    end
    assign done_flag = done_q;

    assign core_stall = go_q && is_flash;

    // =========================================================
    // register read, key reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= 16'h0000;
        end else if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                NUS_ADDR_CTRL: begin
                    sfr_rdata <= {go_q, arm_q, abort_q, 4'h0, timed_q,
                                  1'b0, op_q};
                end
                NUS_ADDR_ADR_LO: sfr_rdata <= adr_lo_q;
                NUS_ADDR_ADR_HI: sfr_rdata <= {8'h00, adr_hi_q};
                default:         sfr_rdata <= 16'h0000;
            endcase
        end
    end

    // =========================================================
    // checks
    // keyed start only
    a_go_needs_key: assert property (@(posedge clk) disable iff (!rstn)
        $rose(go_q) |-> $past(key2_q) && $past(arm_q))
        else $error("go set without key and arm");
    a_go_arm_same: assert property (@(posedge clk) disable iff (!rstn)
        go_req && !arm_q |=> !go_q)
        else $error("go set with arm in same write");
    a_go_no_clear: assert property (@(posedge clk) disable iff (!rstn)
        go_q && !finish |=> go_q)
        else $error("go cleared early");
    // finish sets done and clears go
    a_finish_done: assert property (@(posedge clk) disable iff (!rstn)
        finish |=> !go_q && done_flag)
        else $error("finish did not clear go or set done");
    a_op_length: assert property (@(posedge clk) disable iff (!rstn)
        state_q != NUS_IDLE |-> cnt_q < 32'(OP_CYCLES))
        else $error("operation length wrong");
    // master reset during op sets abort
    a_abort_set: assert property (@(posedge clk) disable iff (!por_n)
        !rstn && run_q |=> abort_q)
        else $error("abort not set by reset");
    a_done_sticky: assert property (@(posedge clk) disable iff (!rstn)
        done_flag && !done_flag_clr |=> done_flag)
        else $error("done flag dropped");
    a_key_zero: assert property (@(posedge clk) disable iff (!rstn)
        sfr_req.rd && sfr_req.addr == NUS_ADDR_KEY |=> sfr_rdata == 16'h0000)
        else $error("key read not zero");
    a_arm_kept: assert property (@(posedge clk) disable iff (!rstn)
        arm_q && !wr_ctrl |=> arm_q)
        else $error("arm cleared by hardware");
    a_key_broken: assert property (@(posedge clk) disable iff (!rstn)
        sfr_req.wr && !wr_key |=> !key1_q && !key2_q)
        else $error("unlock survived other write");
    a_arm_no_stop: assert property (@(posedge clk) disable iff (!rstn)
        state_q != NUS_IDLE && !finish |=> state_q != NUS_IDLE)
        else $error("operation stopped early");
    a_no_stall: assert property (@(posedge clk) disable iff (!rstn)
        go_q && ee_hit |-> !core_stall)
        else $error("eeprom op stalled core");
    c_start: cover property (@(posedge clk) disable iff (!rstn) go_ok);
    c_finish: cover property (@(posedge clk) disable iff (!rstn) finish);
    c_refused: cover property (@(posedge clk) disable iff (!rstn)
        go_req && !go_ok);
    // block program reached
    c_block: cover property (@(posedge clk) disable iff (!rstn)
        state_q == NUS_PROG && blk_op);

endmodule : nus_seq

/* nus_pkg.sv */
// package for the memory unlock and eeprom sequencer
// assumes one 40 MHz clock domain and a 16-bit register port
package nus_pkg;

    // =========================================================
    // register map (byte addresses)
    localparam logic [15:0] NUS_ADDR_CTRL     = 16'h0760;
    localparam logic [15:0] NUS_ADDR_ADR_LO   = 16'h0762;
    localparam logic [15:0] NUS_ADDR_ADR_HI   = 16'h0764;
    localparam logic [15:0] NUS_ADDR_KEY      = 16'h0766;

    // =========================================================
    // control field positions and values
    localparam int          NUS_BIT_GO        = 15;
    localparam int          NUS_BIT_ARM       = 14;
    localparam int          NUS_BIT_ABORT     = 13;
    localparam int          NUS_BIT_TIMED     = 8;
    localparam int          NUS_OP_W          = 7;
    localparam logic [15:0] NUS_CTRL_RESET    = 16'h0000;
    localparam logic [7:0]  NUS_KEY_FIRST     = 8'h55;
    localparam logic [7:0]  NUS_KEY_SECOND    = 8'haa;

    // operation codes (low seven bits of the control value)
    localparam logic [6:0]  NUS_OP_BLK_ERASE  = 7'h45;
    localparam logic [6:0]  NUS_OP_WRD_ERASE  = 7'h44;
    localparam logic [6:0]  NUS_OP_WRD_PROG   = 7'h04;
    localparam logic [6:0]  NUS_OP_BLK_PROG   = 7'h0a;

    // =========================================================
    // eeprom geometry
    localparam int          NUS_EE_WORDS      = 4096;
    localparam int          NUS_EE_AW         = 12;
    localparam int          NUS_BLK_WORDS     = 16;
    localparam int          NUS_BLK_AW        = 4;
    localparam logic [23:0] NUS_EE_BASE       = 24'h7ff000;
    localparam logic [15:0] NUS_ERASED        = 16'hffff;

    // =========================================================
    // timing
    localparam int          NUS_CLK_HZ        = 40_000_000;
    localparam int          NUS_OP_TIME_US    = 2000;
    localparam int          NUS_OP_CYCLES     =
        (NUS_CLK_HZ / 1_000_000) * NUS_OP_TIME_US;

    // =========================================================
    // register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } nus_sfr_req_t;

    // table access request from the core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [23:0] addr;
        logic [15:0] wdata;
    } nus_tbl_req_t;

    // sequencer states
    typedef enum logic [3:0] {
        NUS_IDLE  = 4'b0001,
        NUS_ERASE = 4'b0010,
        NUS_PROG  = 4'b0100,
        NUS_WAIT  = 4'b1000
    } nus_state_t;

endpackage : nus_pkg

/* nus_mem.sv */
// eeprom array model: separate write and read ports, registered read data
// assumes writes and reads come from the sequencer on the same clock
`timescale 1ns/10ps
module nus_mem #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    // =========================================================
    // write and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : nus_mem

/* nus_core_mdl.sv */
// core model: issues register and table accesses to the sequencer
// assumes a free clk; requests change only at its falling edge
`timescale 1ns/10ps
module nus_core_mdl (
    // clock
    input  wire logic                  clk,
    // answers from the sequencer
    input  wire logic           [15:0] sfr_rdata,
    input  wire logic           [15:0] tbl_rdata,
    // requests to the sequencer
    output nus_pkg::nus_sfr_req_t      sfr_req,
    output nus_pkg::nus_tbl_req_t      tbl_req
);
    import nus_pkg::*;

    // idle bus at time zero
    initial begin
        sfr_req = '0;
        tbl_req = '0;
    end

    // =========================================================
    // register access: one strobe, released lines inverted
    task automatic sfr_acc(input logic w, input logic [15:0] a, d,
                           output logic [15:0] q);
        @(negedge clk);
        sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        sfr_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(negedge clk);
        q = sfr_rdata;
    endtask : sfr_acc

    // table access: address held one cycle for registered data
    task automatic tbl_acc(input logic w, input logic [23:0] a,
                           input logic [15:0] d, output logic [15:0] q);
        @(negedge clk);
        tbl_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        tbl_req = '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
        @(negedge clk);
        q = tbl_rdata;
        tbl_req.addr = ~a;
    endtask : tbl_acc

    // one key write
    task automatic key(input logic [15:0] k);
        logic [15:0] q;
        sfr_acc(1'b1, NUS_ADDR_KEY, k, q);
    endtask : key

    // =========================================================
    // start sequence; m: 0 no keys, 1 proper, 2 broken, 3 reversed
    // keys then go, never interrupted
    task automatic start_op(input logic [15:0] c, g, input int m);
        logic [15:0] q;
        sfr_acc(1'b1, NUS_ADDR_CTRL, c, q);
        if (m == 3) key(16'h00aa);
        if (m != 0) key(16'h0055);
        if (m == 2) key(16'h0000);
        if (m == 1 || m == 2) key(16'h00aa);
        sfr_acc(1'b1, NUS_ADDR_CTRL, g, q);
        repeat (2) @(negedge clk);
    endtask : start_op
endmodule : nus_core_mdl

/* nus_seq_tb.sv */
// testbench for the unlock and eeprom sequencer
// assumes nus_core_mdl drives the register and table ports
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))
module nus_seq_tb;
    import nus_pkg::*;
    localparam int OPC = 20;

    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         por_n = 1'b0;
    logic         clr = 1'b0;
    nus_sfr_req_t sfr_req;
    nus_tbl_req_t tbl_req;
    logic [15:0]  sfr_rdata, tbl_rdata, q;
    logic         core_stall, done_flag;
    logic [23:0]  a, b;
    logic [15:0]  d [16];
    int           mismatches = 0;
    int           n_checks = 0;
    int           n;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // =========================================================
    // design and core model
    nus_seq #(.OP_CYCLES(OPC)) dut_u (
        .clk(clk), .rstn(rstn), .por_n(por_n),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .tbl_req(tbl_req), .tbl_rdata(tbl_rdata),
        .core_stall(core_stall), .done_flag(done_flag),
        .done_flag_clr(clr));
    nus_core_mdl core_u (
        .clk(clk), .sfr_rdata(sfr_rdata), .tbl_rdata(tbl_rdata),
        .sfr_req(sfr_req), .tbl_req(tbl_req));

    // =========================================================
    // checking and verdict
    task automatic chk(string nm, logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // even byte address inside the eeprom window
    // eeprom from base up
    function automatic logic [23:0] ee_addr(logic [31:0] r);
        return NUS_EE_BASE | {12'h000, r[10:0], 1'b0};
    endfunction : ee_addr

    task automatic wr(logic [15:0] ad, dt);
        core_u.sfr_acc(1'b1, ad, dt, q);
    endtask : wr

    task automatic rd(logic [15:0] ad);
        core_u.sfr_acc(1'b0, ad, 16'h0000, q);
    endtask : rd

    // wait for completion, check the flag holds, then clear it
    // next operation only after done
    task automatic wait_done;
        n = 0;
        while (done_flag !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
        `CHK("done held", 1'b1, done_flag);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        `CHK("done cleared", 1'b0, done_flag);
    endtask : wait_done

    // proper start, timed wait, arm kept and go cleared
    // no eeprom read while the operation runs
    task automatic run(logic [15:0] c);
        core_u.start_op(c, c | 16'h8000, 1);
        wait_done();
        `CHK("op time", 1'b1, n >= OPC - 4 && n <= OPC - 1);
        rd(NUS_ADDR_CTRL);
        `CHK("ctrl after op", c, q);
    endtask : run

    // =========================================================
    // main sequence
    initial begin
        void'($urandom(8037));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        por_n = 1'b1;
        rd(NUS_ADDR_CTRL);
        `CHK("ctrl reset", NUS_CTRL_RESET, q);
        rd(NUS_ADDR_KEY);
        `CHK("key read", 16'h0000, q);
        wr(NUS_ADDR_ADR_HI, 16'hff7f);
        rd(NUS_ADDR_ADR_HI);
        `CHK("addr high", 16'h007f, q);
        // refused starts: no keys, arm in same write, broken keys, reversed keys
        for (int m = 0; m < 4; m++) begin
            core_u.start_op(m == 1 ? 16'h0044 : 16'h4044, 16'hc044, m);
            rd(NUS_ADDR_CTRL);
            `CHK("refused go", 16'h4044, q);
            `CHK("refused done", 1'b0, done_flag);
        end
        // word erase then word program at a random word
        // erase before word program
        a = ee_addr($urandom);
        wr(NUS_ADDR_ADR_LO, a[15:0]);
        rd(NUS_ADDR_ADR_LO);
        `CHK("addr low", a[15:0], q);
        run(16'h4044);
        core_u.tbl_acc(1'b0, a, 16'h0000, q);
        `CHK("word erase", NUS_ERASED, q);
        d[0] = 16'($urandom);
        core_u.tbl_acc(1'b1, a, d[0], q);
        core_u.start_op(16'h4004, 16'hc004, 1);
        `CHK("no stall", 1'b0, core_stall);
        wr(NUS_ADDR_CTRL, 16'h0004);
        rd(NUS_ADDR_CTRL);
        `CHK("go held", 16'h8004, q);
        wait_done();
        core_u.tbl_acc(1'b0, a, 16'h0000, q);
        `CHK("word prog", d[0], q);
        // block program then block erase
        b = ee_addr($urandom) & 24'hffffe0;
        for (int i = 0; i < NUS_BLK_WORDS; i++) begin
            d[i] = 16'($urandom);
            core_u.tbl_acc(1'b1, b + 24'(2 * i), d[i], q);
        end
        run(16'h400a);
        for (int i = 0; i < NUS_BLK_WORDS; i++) begin
            core_u.tbl_acc(1'b0, b + 24'(2 * i), 16'h0000, q);
            `CHK("block prog", d[i], q);
        end
        wr(NUS_ADDR_ADR_LO, b[15:0] | 16'h0016);
        run(16'h4045);
        for (int i = 0; i < NUS_BLK_WORDS; i++) begin
            core_u.tbl_acc(1'b0, b + 24'(2 * i), 16'h0000, q);
            `CHK("block erase", NUS_ERASED, q);
        end
        // flash address stalls the core
        wr(NUS_ADDR_ADR_HI, 16'h0000);
        core_u.start_op(16'h4044, 16'hc044, 1);
        `CHK("flash stall", 1'b1, core_stall);
        wait_done();
        rd(NUS_ADDR_CTRL);
        `CHK("flash go clear", 16'h4044, q);
        // reset in mid-operation
        wr(NUS_ADDR_ADR_HI, 16'h007f);
        wr(NUS_ADDR_ADR_LO, a[15:0]);
        core_u.start_op(16'h4044, 16'hc044, 1);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        rd(NUS_ADDR_CTRL);
        `CHK("abort flag", 16'h2000, q);
        rd(NUS_ADDR_ADR_LO);
        `CHK("addr kept", a[15:0], q);
        final_report();
    end

    // hang guard
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule : nus_seq_tb
